// ==== hw/dps_defs.svh ====
`ifndef DPS_DEFS_SVH
`define DPS_DEFS_SVH
// Command encodings {cs_n, ras_n, cas_n, we_n}; the strobe pins are active low
`define DPS_CMD_DESEL 4'hf
`define DPS_CMD_NOP 4'h7
`define DPS_CMD_MRS 4'h0
`define DPS_CMD_REF 4'h1
`define DPS_CMD_PRE 4'h2
`define DPS_CMD_ACT 4'h3
`define DPS_CMD_WR 4'h4
`define DPS_CMD_RD 4'h5
`define DPS_CMD_ZQC 4'h6
// Postamble count; the strobe driver is held one cycle more than this after a write burst
`define DPS_WR_POST 2'h1
// Bit positions in the packed FIFO word: {mask[1:0], data[15:0]}
`define DPS_MASK_LSB 16
`define DPS_FIFO_W 18
`endif

// ==== hw/dps_pkg.sv ====
`include "dps_defs.svh"
package dps_pkg;
    // Operations the user side may request
    typedef enum logic [3:0] {
        DPS_OP_NOP = 4'h0,
        DPS_OP_MRS = 4'h1,
        DPS_OP_REF = 4'h2,
        DPS_OP_PRE = 4'h3,
        DPS_OP_ACT = 4'h4,
        DPS_OP_WR = 4'h5,
        DPS_OP_RD = 4'h6,
        DPS_OP_ZQC = 4'h7
    } dps_op_t;
    // Direction state of the data and strobe drivers, one-hot
    typedef enum logic [2:0] {
        DPS_ST_IDLE = 3'b001,
        DPS_ST_WRITE = 3'b010,
        DPS_ST_POST = 3'b100
    } dps_state_t;
endpackage : dps_pkg

// ==== hw/dps_fifo_if.sv ====
// Carries the write beats between the FIFO and the pin sequencer
interface dps_fifo_if #(parameter int WIDTH = 18);
    logic in_valid;
    logic in_ready;
    logic [WIDTH-1:0] in_data;
    logic out_valid;
    logic out_ready;
    logic [WIDTH-1:0] out_data;
    modport fifo (input in_valid, in_data, out_ready, output in_ready, out_valid, out_data);
    modport user (output in_valid, in_data, out_ready, input in_ready, out_valid, out_data);
endinterface : dps_fifo_if

// ==== hw/dps_fifo.sv ====
// Registered-output FIFO of write beats; depth must be a power of two
module dps_fifo #(
    parameter int WIDTH = 18,
    parameter int DEPTH = 8
) (
    input wire logic core_clk_i,
    input wire logic srst_i,
    input wire logic ce_i,
    dps_fifo_if.fifo port_if
);
    localparam int AW = $clog2(DEPTH);
    // Pointer wrap and the full test only work on a power-of-two depth
    if (WIDTH < 1 || DEPTH < 2 || (1 << AW) != DEPTH) begin : g_bad_param
        $error("dps_fifo: DEPTH must be a power of two");
    end
    logic [WIDTH-1:0] mem_reg [DEPTH];
    logic [AW:0] wr_ptr_reg;
    logic [AW:0] rd_ptr_reg;
    logic [WIDTH-1:0] out_reg;
    logic out_valid_reg;
    logic empty;
    logic full;
    logic do_wr;
    logic do_load;
    assign empty = (wr_ptr_reg == rd_ptr_reg);
    assign full = (wr_ptr_reg[AW-1:0] == rd_ptr_reg[AW-1:0]) && (wr_ptr_reg[AW] != rd_ptr_reg[AW]);
    assign do_wr = port_if.in_valid && !full;
    // Output register refills when empty or being drained
    assign do_load = !empty && (!out_valid_reg || port_if.out_ready);
    assign port_if.in_ready = !full;
    assign port_if.out_valid = out_valid_reg;
    assign port_if.out_data = out_reg;
    // Storage array, no reset so it maps to plain RAM
    always_ff @(posedge core_clk_i) begin
        if (ce_i && do_wr) begin
            mem_reg[wr_ptr_reg[AW-1:0]] <= port_if.in_data;
        end
    end
    // Write pointer
    always_ff @(posedge core_clk_i) begin
        if (srst_i) begin
            wr_ptr_reg <= '0;
        end else if (ce_i && do_wr) begin
            wr_ptr_reg <= wr_ptr_reg + 1'b1;
        end
    end
    // Read pointer and registered read data
    always_ff @(posedge core_clk_i) begin
        if (srst_i) begin
            rd_ptr_reg <= '0;
            out_reg <= '0;
            out_valid_reg <= 1'b0;
        end else if (ce_i) begin
            if (do_load) begin
                out_reg <= mem_reg[rd_ptr_reg[AW-1:0]];
                rd_ptr_reg <= rd_ptr_reg + 1'b1;
                out_valid_reg <= 1'b1;
            end else if (port_if.out_ready) begin
                out_valid_reg <= 1'b0;
            end
        end
    end
endmodule : dps_fifo

// ==== hw/dps_pins.sv ====
`include "dps_defs.svh"
module dps_pins
    import dps_pkg::*;
#(
    parameter int DEPTH = 8,
    parameter int ADDR_W = 14,
    parameter int BANK_W = 3
) (
    input wire logic core_clk_i,
    input wire logic srst_i,
    input wire logic ce_i,
    // Command request
    input wire logic cmd_valid_i,
    input wire dps_op_t cmd_op_i,
    input wire logic [BANK_W-1:0] cmd_bank_i,
    input wire logic [ADDR_W-1:0] cmd_addr_i,
    output logic cmd_ready_o,
    // Write beat stream
    input wire logic wr_valid_i,
    input wire logic [15:0] wr_data_i,
    input wire logic [1:0] wr_mask_i,
    output logic wr_ready_o,
    // Read beat stream
    output logic rd_valid_o,
    output logic [15:0] rd_data_o,
    // Level controls
    input wire logic diff_strobe_i,
    input wire logic odt_req_i,
    input wire logic cke_req_i,
    // Memory pins
    output logic mem_chip_select_n_o,
    output logic row_command_strobe_n_o,
    output logic column_command_strobe_n_o,
    output logic write_command_strobe_n_o,
    output logic [BANK_W-1:0] bank_select_o,
    output logic [ADDR_W-1:0] mem_addr_o,
    output logic mem_clock_enable_o,
    output logic termination_control_o,
    output logic lower_byte_write_mask_o,
    output logic upper_byte_write_mask_o,
    input wire logic [15:0] mem_data_lines_i,
    output logic [15:0] mem_data_lines_o,
    output logic mem_data_lines_oe_o,
    input wire logic lower_byte_strobe_i,
    output logic lower_byte_strobe_o,
    output logic lower_byte_strobe_oe_o,
    output logic lower_byte_strobe_c_o,
    output logic lower_byte_strobe_c_oe_o,
    input wire logic upper_byte_strobe_i,
    output logic upper_byte_strobe_o,
    output logic upper_byte_strobe_oe_o,
    output logic upper_byte_strobe_c_o,
    output logic upper_byte_strobe_c_oe_o
);
    // Refuse empty address or bank buses at elaboration
    if (ADDR_W < 1 || BANK_W < 1) begin : g_bad_width
        $error("dps_pins: address widths must be positive");
    end
    dps_fifo_if #(.WIDTH(`DPS_FIFO_W)) wq_if ();
    dps_state_t state_reg;
    dps_state_t state_next;
    logic [3:0] cmd_code;        // {cs_n, ras_n, cas_n, we_n}
    logic [1:0] post_cnt_reg;    // Postamble countdown
    logic strobe_phase_reg;      // Toggles once per driven beat
    logic diff_reg;              // Strobe mode, sampled each cycle
    logic rd_strobe_d_reg;       // Previous lower read strobe for edge capture
    logic beat_take;
    // Write beats queue so bursts can be fed ahead of the command
    dps_fifo #(.WIDTH(`DPS_FIFO_W), .DEPTH(DEPTH)) u_fifo (
        .core_clk_i(core_clk_i),
        .srst_i(srst_i),
        .ce_i(ce_i),
        .port_if(wq_if)
    );
    assign wq_if.in_valid = wr_valid_i;
    assign wq_if.in_data = {wr_mask_i, wr_data_i};
    assign wq_if.out_ready = (state_reg == DPS_ST_WRITE);
    assign beat_take = wq_if.out_valid && wq_if.out_ready;
    // Back-pressure mirrored onto a flop to keep outputs registered
    always_ff @(posedge core_clk_i) begin
        if (srst_i) begin
            wr_ready_o <= 1'b0;
        end else if (ce_i) begin
            wr_ready_o <= wq_if.in_ready;
        end
    end
    // Map the requested operation onto the pin code
    always_comb begin
        unique case (cmd_op_i)
            DPS_OP_MRS: cmd_code = `DPS_CMD_MRS;
            DPS_OP_REF: cmd_code = `DPS_CMD_REF;
            DPS_OP_PRE: cmd_code = `DPS_CMD_PRE;
            DPS_OP_ACT: cmd_code = `DPS_CMD_ACT;
            DPS_OP_WR: cmd_code = `DPS_CMD_WR;
            DPS_OP_RD: cmd_code = `DPS_CMD_RD;
            DPS_OP_ZQC: cmd_code = `DPS_CMD_ZQC;
            default: cmd_code = `DPS_CMD_NOP;
        endcase
    end
    // Commands only taken while no write burst owns the bus
    always_ff @(posedge core_clk_i) begin
        if (srst_i) begin
            cmd_ready_o <= 1'b0;
        end else if (ce_i) begin
            cmd_ready_o <= (state_next == DPS_ST_IDLE);
        end
    end
    // Command pins; chip select low exactly in a command cycle
    always_ff @(posedge core_clk_i) begin
        if (srst_i) begin
            {mem_chip_select_n_o, row_command_strobe_n_o, column_command_strobe_n_o,
                write_command_strobe_n_o} <= `DPS_CMD_DESEL;
            bank_select_o <= '0;
            mem_addr_o <= '0;
        end else if (ce_i) begin
            if (cmd_valid_i && cmd_ready_o) begin
                {mem_chip_select_n_o, row_command_strobe_n_o, column_command_strobe_n_o,
                    write_command_strobe_n_o} <= cmd_code;
                bank_select_o <= cmd_bank_i;
                mem_addr_o <= cmd_addr_i;
            end else begin
                // Deselect keeps the memory ignoring the other pins
                {mem_chip_select_n_o, row_command_strobe_n_o, column_command_strobe_n_o,
                    write_command_strobe_n_o} <= `DPS_CMD_DESEL;
            end
        end
    end
    // Clock enable and termination follow their own requests only
    always_ff @(posedge core_clk_i) begin
        if (srst_i) begin
            mem_clock_enable_o <= 1'b0;
            termination_control_o <= 1'b0;
        end else if (ce_i) begin
            mem_clock_enable_o <= cke_req_i;
            termination_control_o <= odt_req_i;
        end
    end
    // Driver direction: write burst drives, idle releases for reads
    always_comb begin
        state_next = state_reg;
        unique case (state_reg)
            DPS_ST_IDLE: if (cmd_valid_i && cmd_ready_o && cmd_op_i == DPS_OP_WR) begin
                state_next = DPS_ST_WRITE;
            end
            DPS_ST_WRITE: if (!wq_if.out_valid) begin
                state_next = DPS_ST_POST;
            end
            DPS_ST_POST: if (post_cnt_reg == 2'h0) begin
                state_next = DPS_ST_IDLE;
            end
            default: state_next = DPS_ST_IDLE;
        endcase
    end
    always_ff @(posedge core_clk_i) begin
        if (srst_i) begin
            state_reg <= DPS_ST_IDLE;
        end else if (ce_i) begin
            state_reg <= state_next;
        end
    end
    // Postamble counter holds the strobe a little after the last beat
    always_ff @(posedge core_clk_i) begin
        if (srst_i) begin
            post_cnt_reg <= '0;
        end else if (ce_i) begin
            if (state_reg == DPS_ST_WRITE) begin
                post_cnt_reg <= `DPS_WR_POST;
            end else if (post_cnt_reg != 2'h0) begin
                post_cnt_reg <= post_cnt_reg - 2'h1;
            end
        end
    end
    // Data, masks and strobes; one beat per cycle, mask stable per beat
    always_ff @(posedge core_clk_i) begin
        if (srst_i) begin
            mem_data_lines_o <= '0;
            mem_data_lines_oe_o <= 1'b0;
            lower_byte_write_mask_o <= 1'b1;
            upper_byte_write_mask_o <= 1'b1;
            strobe_phase_reg <= 1'b0;
        end else if (ce_i) begin
            mem_data_lines_oe_o <= (state_next != DPS_ST_IDLE);
            if (beat_take) begin
                mem_data_lines_o <= wq_if.out_data[15:0];
                // Mask bit set means the byte is not written
                lower_byte_write_mask_o <= wq_if.out_data[`DPS_MASK_LSB];
                upper_byte_write_mask_o <= wq_if.out_data[`DPS_MASK_LSB+1];
                strobe_phase_reg <= ~strobe_phase_reg;
            end else begin
                // No beat: mask both lanes so nothing stray is written
                lower_byte_write_mask_o <= 1'b1;
                upper_byte_write_mask_o <= 1'b1;
                strobe_phase_reg <= 1'b0;
            end
        end
    end
    // Strobe pins; the complements only toggle in differential mode
    always_ff @(posedge core_clk_i) begin
        if (srst_i) begin
            diff_reg <= 1'b0;
            lower_byte_strobe_o <= 1'b0;
            upper_byte_strobe_o <= 1'b0;
            lower_byte_strobe_oe_o <= 1'b0;
            upper_byte_strobe_oe_o <= 1'b0;
            lower_byte_strobe_c_o <= 1'b0;
            upper_byte_strobe_c_o <= 1'b0;
            lower_byte_strobe_c_oe_o <= 1'b0;
            upper_byte_strobe_c_oe_o <= 1'b0;
        end else if (ce_i) begin
            diff_reg <= diff_strobe_i;
            lower_byte_strobe_oe_o <= (state_next != DPS_ST_IDLE);
            upper_byte_strobe_oe_o <= (state_next != DPS_ST_IDLE);
            lower_byte_strobe_o <= beat_take && !strobe_phase_reg;
            upper_byte_strobe_o <= beat_take && !strobe_phase_reg;
            // Complements are left undriven when single-ended
            lower_byte_strobe_c_oe_o <= diff_reg && (state_next != DPS_ST_IDLE);
            upper_byte_strobe_c_oe_o <= diff_reg && (state_next != DPS_ST_IDLE);
            lower_byte_strobe_c_o <= diff_reg && !(beat_take && !strobe_phase_reg);
            upper_byte_strobe_c_o <= diff_reg && !(beat_take && !strobe_phase_reg);
        end
    end
    // Read capture on a strobe change while the pins are released
    always_ff @(posedge core_clk_i) begin
        if (srst_i) begin
            rd_strobe_d_reg <= 1'b0;
            rd_valid_o <= 1'b0;
            rd_data_o <= '0;
        end else if (ce_i) begin
            rd_strobe_d_reg <= lower_byte_strobe_i;
            // Upper strobe assumed aligned with the lower one at this rate
            rd_valid_o <= (state_reg == DPS_ST_IDLE) && !lower_byte_strobe_oe_o
                && (lower_byte_strobe_i != rd_strobe_d_reg);
            rd_data_o <= mem_data_lines_i;
        end
    end
endmodule : dps_pins

// ==== sim/dps_pins_asserts.sv ====
`include "dps_defs.svh"
// Watches command, level and strobe pins of the pin sequencer
module dps_pins_asserts
    import dps_pkg::*;
#(
    parameter int ADDR_W = 14,
    parameter int BANK_W = 3
) (
    input wire logic core_clk_i,
    input wire logic srst_i,
    input wire logic ce_i,
    input wire logic cmd_valid_i,
    input wire dps_op_t cmd_op_i,
    input wire logic [BANK_W-1:0] cmd_bank_i,
    input wire logic [ADDR_W-1:0] cmd_addr_i,
    input wire logic cmd_ready_o,
    input wire logic diff_strobe_i,
    input wire logic odt_req_i,
    input wire logic cke_req_i,
    input wire logic mem_chip_select_n_o,
    input wire logic row_command_strobe_n_o,
    input wire logic column_command_strobe_n_o,
    input wire logic write_command_strobe_n_o,
    input wire logic [BANK_W-1:0] bank_select_o,
    input wire logic [ADDR_W-1:0] mem_addr_o,
    input wire logic mem_clock_enable_o,
    input wire logic termination_control_o,
    input wire logic lower_byte_write_mask_o,
    input wire logic upper_byte_write_mask_o,
    input wire logic mem_data_lines_oe_o,
    input wire logic lower_byte_strobe_o,
    input wire logic lower_byte_strobe_oe_o,
    input wire logic lower_byte_strobe_c_o,
    input wire logic lower_byte_strobe_c_oe_o,
    input wire logic upper_byte_strobe_o,
    input wire logic upper_byte_strobe_oe_o,
    input wire logic upper_byte_strobe_c_o,
    input wire logic upper_byte_strobe_c_oe_o
);
    timeunit 1ns;
    timeprecision 100ps;
    // Pin code per operation, indexed by the operation value
    localparam logic [3:0] CODE [8] = '{`DPS_CMD_NOP, `DPS_CMD_MRS, `DPS_CMD_REF,
        `DPS_CMD_PRE, `DPS_CMD_ACT, `DPS_CMD_WR, `DPS_CMD_RD, `DPS_CMD_ZQC};
    logic took; // Command accepted at this edge
    logic [3:0] pins; // Command pins as one code
    assign took = cmd_valid_i && cmd_ready_o && ce_i;
    assign pins = {mem_chip_select_n_o, row_command_strobe_n_o, column_command_strobe_n_o,
        write_command_strobe_n_o};
    default clocking cb @(posedge core_clk_i);
    endclocking
    default disable iff (srst_i);
    AST_CMD_CS: assert property (took |=> !mem_chip_select_n_o)
        else $error("command shown without chip select");
    AST_IDLE_DESEL: assert property (ce_i && !took |=> pins == `DPS_CMD_DESEL)
        else $error("pins not deselected without a command");
    AST_CMD_CODE: assert property (took |=> pins == CODE[$past(cmd_op_i)])
        else $error("wrong command code on pins");
    AST_CMD_BANK: assert property (took |=> bank_select_o == $past(cmd_bank_i)
        && mem_addr_o == $past(cmd_addr_i)) else $error("bank or address wrong");
    AST_ODT_FOLLOW: assert property (ce_i |=> termination_control_o == $past(odt_req_i))
        else $error("termination does not follow its request");
    AST_CKE_FOLLOW: assert property (ce_i |=> mem_clock_enable_o == $past(cke_req_i))
        else $error("clock enable does not follow its request");
    AST_STROBE_DATA: assert property (mem_data_lines_oe_o |-> lower_byte_strobe_oe_o
        && upper_byte_strobe_oe_o) else $error("data driven without strobes");
    AST_MASK_IDLE: assert property (!mem_data_lines_oe_o |-> lower_byte_write_mask_o
        && upper_byte_write_mask_o) else $error("mask open outside a beat");
    // Mode input reaches the complement pins two edges late, so look back two
    AST_DIFF_PAIR: assert property (diff_strobe_i && $past(diff_strobe_i)
        && $past(diff_strobe_i, 2) && lower_byte_strobe_oe_o |-> lower_byte_strobe_c_oe_o
        && lower_byte_strobe_c_o != lower_byte_strobe_o) else $error("complement strobe wrong");
    AST_SE_UNUSED: assert property (!diff_strobe_i && !$past(diff_strobe_i)
        && !$past(diff_strobe_i, 2)
        |-> !lower_byte_strobe_c_oe_o && !upper_byte_strobe_c_oe_o)
        else $error("complement strobe driven in single-ended mode");
    AST_UPPER_LANE: assert property (upper_byte_strobe_oe_o == lower_byte_strobe_oe_o
        && upper_byte_strobe_o == lower_byte_strobe_o
        && upper_byte_strobe_c_oe_o == lower_byte_strobe_c_oe_o
        && upper_byte_strobe_c_o == lower_byte_strobe_c_o)
        else $error("upper strobe lane differs from lower lane");
endmodule : dps_pins_asserts

// ==== sim/dps_mem_model.sv ====
// Far-side memory: records write beats and answers reads with strobed beats
module dps_mem_model (
    input wire logic core_clk_i,
    input wire logic [15:0] dq_i,
    input wire logic dq_oe_i,
    input wire logic [1:0] dm_i,
    input wire logic ls_i,
    input wire logic ls_oe_i,
    input wire logic us_i,
    input wire logic us_oe_i,
    output logic [15:0] dq_o,
    output logic ls_o,
    output logic us_o
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [15:0] drv_dq = 16'h0; // Data put out on reads
    logic ls_last = 1'b0; // Lower strobe level seen at the previous edge
    logic drv_s = 1'b0; // Strobe parked low between bursts
    logic [17:0] wq [$]; // Write beats seen, {masks, data}
    // Whoever enables its driver owns the line
    assign dq_o = dq_oe_i ? dq_i : drv_dq;
    assign ls_o = ls_oe_i ? ls_i : drv_s;
    assign us_o = us_oe_i ? us_i : drv_s;
    // One beat per strobe edge while the controller drives, mask taken with its data;
    // a trailing edge after an odd burst is recorded too, so its mask can be judged
    always @(posedge core_clk_i) begin
        if (ls_oe_i && ls_i != ls_last) begin
            wq.push_back({dm_i, dq_i});
        end
        ls_last <= ls_i;
    end
    // Read burst: one beat per strobe edge, launched off the falling edge
    task automatic read_burst(input int n, input logic [15:0] base);
        for (int i = 0; i < n; i++) begin
            @(negedge core_clk_i);
            drv_dq = base + 16'(i);
            drv_s = ~drv_s;
        end
        @(negedge core_clk_i);
        drv_dq = ~drv_dq; // Released lines must not keep the last beat
    endtask : read_burst
endmodule : dps_mem_model

// ==== sim/testbench.sv ====
`include "dps_defs.svh"
module testbench
    import dps_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;
    localparam logic [3:0] CODE [8] = '{`DPS_CMD_NOP, `DPS_CMD_MRS, `DPS_CMD_REF,
        `DPS_CMD_PRE, `DPS_CMD_ACT, `DPS_CMD_WR, `DPS_CMD_RD, `DPS_CMD_ZQC};
    logic core_clk_i = 1'b0;
    logic srst_i = 1'b1;
    logic ce_i = 1'b1;
    logic cmd_valid_i = 1'b0;
    dps_op_t cmd_op_i = DPS_OP_NOP;
    logic [2:0] cmd_bank_i = 3'h0;
    logic [13:0] cmd_addr_i = 14'h0;
    logic wr_valid_i = 1'b0;
    logic [15:0] wr_data_i = 16'h0;
    logic [1:0] wr_mask_i = 2'h0;
    logic diff_strobe_i = 1'b0;
    logic odt_req_i = 1'b0;
    logic cke_req_i = 1'b0;
    logic cmd_ready_o, wr_ready_o, rd_valid_o, mem_data_lines_oe_o;
    logic [15:0] rd_data_o, mem_data_lines_i, mem_data_lines_o;
    logic mem_chip_select_n_o, row_command_strobe_n_o, column_command_strobe_n_o;
    logic write_command_strobe_n_o, mem_clock_enable_o, termination_control_o;
    logic [2:0] bank_select_o;
    logic [13:0] mem_addr_o;
    logic lower_byte_write_mask_o, upper_byte_write_mask_o;
    logic lower_byte_strobe_i, lower_byte_strobe_o, lower_byte_strobe_oe_o;
    logic lower_byte_strobe_c_o, lower_byte_strobe_c_oe_o;
    logic upper_byte_strobe_i, upper_byte_strobe_o, upper_byte_strobe_oe_o;
    logic upper_byte_strobe_c_o, upper_byte_strobe_c_oe_o;
    logic [3:0] pins; // Command pins as one code
    int n_mismatch = 0;
    int cmp_count = 0;
    assign pins = {mem_chip_select_n_o, row_command_strobe_n_o, column_command_strobe_n_o,
        write_command_strobe_n_o};
    always #12.5 core_clk_i = ~core_clk_i;
    dps_pins #(.DEPTH(8), .ADDR_W(14), .BANK_W(3)) uut (.*);
    dps_mem_model mem (.core_clk_i(core_clk_i), .dq_i(mem_data_lines_o),
        .dq_oe_i(mem_data_lines_oe_o), .dm_i({upper_byte_write_mask_o, lower_byte_write_mask_o}),
        .ls_i(lower_byte_strobe_o), .ls_oe_i(lower_byte_strobe_oe_o), .us_i(upper_byte_strobe_o),
        .us_oe_i(upper_byte_strobe_oe_o), .dq_o(mem_data_lines_i), .ls_o(lower_byte_strobe_i),
        .us_o(upper_byte_strobe_i));
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("[ERR] %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk
    task automatic test_done();
        $display("Mismatches %0d, comparisons %0d", n_mismatch, cmp_count);
        if (n_mismatch == 0 && cmp_count > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : test_done
    // Issue n commands back to back; each is judged as it lands on the pins
    task automatic do_cmd(input int first, input int n);
        int k;
        for (int i = first; i < first + n; i++) begin
            cmd_valid_i = 1'b1;
            cmd_op_i = dps_op_t'(i);
            cmd_bank_i = 3'(i);
            cmd_addr_i = 14'h2a5 ^ 14'(i * 273);
            k = 0;
            // Ready is looked at where it is settled; the next rising edge takes it
            while (cmd_ready_o !== 1'b1 && k < 40) begin
                @(negedge core_clk_i);
                k++;
            end
            @(negedge core_clk_i);
            chk("ready", 32'(k < 40), 32'h1);
            chk("cmd", pins, CODE[i]);
            chk("bank", {bank_select_o, mem_addr_o}, {3'(i), 14'h2a5 ^ 14'(i * 273)});
        end
        cmd_valid_i = 1'b0;
    endtask : do_cmd
    // Pins idle after reset, clock enable follows request
    task automatic t_reset();
        chk("idle", pins, `DPS_CMD_DESEL);
        chk("masks", {upper_byte_write_mask_o, lower_byte_write_mask_o}, 2'h3);
        chk("oe", {mem_data_lines_oe_o, lower_byte_strobe_oe_o}, 2'h0);
        cke_req_i = 1'b1;
        @(negedge core_clk_i);
        chk("cke", mem_clock_enable_o, 1'b1);
    endtask : t_reset
    // Clock enable low must keep a pending command off the pins
    task automatic t_hold();
        @(negedge core_clk_i);
        ce_i = 1'b0;
        cmd_valid_i = 1'b1;
        repeat (3) @(negedge core_clk_i);
        chk("frozen", pins, `DPS_CMD_DESEL);
        ce_i = 1'b1;
        cmd_valid_i = 1'b0;
    endtask : t_hold
    // Fill the buffer past full, then write it out; termination held high throughout
    task automatic t_write(input logic d);
        @(negedge core_clk_i);
        diff_strobe_i = d;
        odt_req_i = 1'b1;
        mem.wq.delete();
        // Capacity is eight stored words plus the registered output word
        for (int i = 0; i < 10; i++) begin
            wr_valid_i = 1'b1;
            wr_data_i = 16'h0f00 ^ 16'(i * 4951);
            wr_mask_i = 2'(i);
            @(negedge core_clk_i);
        end
        wr_valid_i = 1'b0;
        chk("full", wr_ready_o, 1'b0);
        do_cmd(int'(DPS_OP_WR), 1);
        repeat (14) @(negedge core_clk_i);
        chk("beats", 32'(mem.wq.size() >= 9), 32'h1);
        for (int i = 0; i < mem.wq.size(); i++) begin
            if (i < 9) begin
                chk("beat", mem.wq[i], {2'(i), 16'h0f00 ^ 16'(i * 4951)});
            end else begin
                chk("tail mask", mem.wq[i][17:16], 2'h3);
            end
        end
        chk("space", wr_ready_o, 1'b1);
        chk("odt", termination_control_o, 1'b1);
        odt_req_i = 1'b0;
    endtask : t_write
    // Memory answers a read with four strobed beats
    task automatic t_read();
        logic [15:0] q [$];
        do_cmd(int'(DPS_OP_RD), 1);
        fork
            mem.read_burst(4, 16'hc3a0);
            repeat (8) begin
                @(negedge core_clk_i);
                if (rd_valid_o === 1'b1) begin
                    q.push_back(rd_data_o);
                end
            end
        join
        chk("reads", q.size(), 4);
        for (int i = 0; i < q.size(); i++) begin
            chk("rdata", q[i], 16'hc3a0 + 16'(i));
        end
    endtask : t_read
    initial begin
        repeat (8) @(negedge core_clk_i);
        srst_i = 1'b0;
        @(negedge core_clk_i);
        t_reset();
        do_cmd(0, 8);
        t_hold();
        t_write(1'b1);
        t_write(1'b0);
        t_read();
        test_done();
    end
    // Whole run is about a hundred cycles; cut a hang well beyond that
    initial begin
        #(25 * 3000);
        n_mismatch++;
        test_done();
    end
endmodule : testbench
bind dps_pins dps_pins_asserts #(.ADDR_W(ADDR_W), .BANK_W(BANK_W)) u_ast (.*);
